// ===== logic/rtcts_defs.vh
// register offsets, field positions, reset values and timing counts for the trim/backup block
`ifndef RTCTS_DEFS_VH
`define RTCTS_DEFS_VH
`define RTCTS_ADDR_WKDAY      5'h03
`define RTCTS_ADDR_CONTROL    5'h07
`define RTCTS_ADDR_TRIM       5'h08
`define RTCTS_ADDR_ALM0WK     5'h0D
`define RTCTS_ADDR_ALM1WK     5'h14
`define RTCTS_ADDR_PD_BASE    5'h18
`define RTCTS_ADDR_PU_BASE    5'h1C
`define RTCTS_CTRL_RESET      8'h80
`define RTCTS_TRIM_RESET      8'h00
`define RTCTS_CTRL_OUT        7
`define RTCTS_CTRL_SQUARE_WAVE_ENABLE      6
`define RTCTS_CTRL_ALARM_ONE_ENABLE     5
`define RTCTS_CTRL_ALARM_ZERO_ENABLE     4
`define RTCTS_CTRL_EXTERNAL_CLOCK_ENABLE     3
`define RTCTS_CTRL_CRS        2
`define RTCTS_TRIM_SIGN       7
`define RTCTS_WK_POWER_FAIL_FLAG      4
`define RTCTS_WK_BACKUP_INPUT_ENABLE       3
`define RTCTS_ALM_POL         7
`define RTCTS_ALM_IF          3
`define RTCTS_OSC_HZ          32768
`define RTCTS_TICKS_PER_MIN   (`RTCTS_OSC_HZ * 60)
`define RTCTS_TICKS_COARSE    (`RTCTS_OSC_HZ / 128)
`define RTCTS_DIV_1HZ         32768
`define RTCTS_DIV_4K          8
`define RTCTS_DIV_8K          4
`endif

// ===== logic/rtcts_timebase.v
// trimmed timebase: counts oscillator ticks, adds or drops cycles at trim events
`timescale 1ns/10ps
`include "rtcts_defs.vh"
module rtcts_timebase #(
    parameter CNT_W = 21
) (
    input  wire             clock_i,
    input  wire             rst_n_i,
    input  wire             ce_i,
    input  wire             tick_i,
    input  wire             coarse_i,
    input  wire [7:0]       trim_i,
    output reg  [CNT_W-1:0] phase_o
);
    reg [CNT_W-1:0] period_cnt_q;
    reg [7:0]       pend_q;
    reg             pend_sign_q;
    wire [31:0]      period_full = coarse_i ? `RTCTS_TICKS_COARSE : `RTCTS_TICKS_PER_MIN;
    wire [CNT_W-1:0] period      = period_full[CNT_W-1:0];
    wire event_w = (period_cnt_q >= period - 1'b1);
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            period_cnt_q <= {CNT_W{1'b0}};
            pend_q       <= 8'h00;
            pend_sign_q  <= 1'b0;
            phase_o      <= {CNT_W{1'b0}};
        end else if (ce_i && tick_i) begin
            period_cnt_q <= event_w ? {CNT_W{1'b0}} : period_cnt_q + 1'b1;
            if (event_w && pend_q == 8'h00) begin
                // latched only here so a new write never disturbs a running adjustment
                pend_q      <= {trim_i[6:0], 1'b0};
                pend_sign_q <= trim_i[`RTCTS_TRIM_SIGN];
            end
            if (pend_q != 8'h00) begin
                pend_q <= pend_q - 8'h01;
                // add: double step; subtract: hold the phase
                phase_o <= pend_sign_q ? phase_o + 2'd2 : phase_o;
            end else begin
                phase_o <= phase_o + 1'b1;
            end
        end
    end
endmodule // rtcts_timebase

// ===== logic/rtcts_core.v
// multi-function pin control, digital trim, backup switchover and power-fail stamps
`timescale 1ns/10ps
`include "rtcts_defs.vh"
// Overview of operation
// - all outputs disabled: pin is general output
// - general output level follows control bit 7
// - fine trim applied once per minute
// - sign one adds cycles, zero subtracts
// - each trim step is two oscillator cycles
// - zero magnitude disables trimming
// - trimming continues on backup supply
// - coarse mode trims 128 times per second
// - coarse plus square wave gives 64 Hz
// - no 64 Hz output on backup
// - automatic switch to backup below threshold
// - backup used only when input enabled
// - timekeeping, alarms, trim, contents kept on backup
// - bus, square wave, general output off
// - stamp time at power loss and restore
// - power-fail flag set on logged failure
// - stamps frozen while flag set
// - clearing flag clears all stamps
// - rate select divides 32768, 8, 4, 2
// - square wave first, then alarm output
// - control register sits at 0x07
module rtcts_core #(
    parameter CNT_W = 21
) (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    input  wire        osc_tick_i,
    input  wire        vcc_below_trip_i,
    input  wire [7:0]  cal_min_i,
    input  wire [7:0]  cal_hour_i,
    input  wire [7:0]  cal_date_i,
    input  wire [7:0]  cal_mth_i,
    input  wire        alarm_zero_flag_i,
    input  wire        alarm_one_flag_i,
    input  wire        reg_wr_i,
    input  wire [4:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    output reg         bus_enable_o,
    output reg         on_backup_o,
    output reg         mfp_o,
    output reg         mfp_oe_n_o,
    output reg  [CNT_W-1:0] time_phase_o
);
    reg [7:0]  ctrl_q;
    reg [7:0]  trim_q;
    reg        vbat_en_q;
    reg        pwr_fail_q;
    reg        alarm_polarity_q;
    reg [7:0]  pd_q [0:3];
    reg [7:0]  pu_q [0:3];
    reg        backup_q;
    reg [14:0] div_q;
    reg        level_d;
    wire [CNT_W-1:0] phase_w;
    integer    i;

    function [7:0] stamp_mask;
        input [1:0] idx;
        begin
            case (idx)
                2'd0:    stamp_mask = 8'h7F;
                2'd1:    stamp_mask = 8'h7F;
                2'd2:    stamp_mask = 8'h3F;
                default: stamp_mask = 8'hFF;
            endcase
        end
    endfunction

    rtcts_timebase #(
        .CNT_W (CNT_W)
    ) u_timebase (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .ce_i     (ce_i),
        .tick_i   (osc_tick_i),
        .coarse_i (ctrl_q[`RTCTS_CTRL_CRS]),
        .trim_i   (trim_q),
        .phase_o  (phase_w)
    );

    wire go_backup = vcc_below_trip_i && vbat_en_q;
    wire bus_wr    = reg_wr_i && !backup_q;
    wire clr_flag  = bus_wr && reg_addr_i == `RTCTS_ADDR_WKDAY
                     && !reg_wdata_i[`RTCTS_WK_POWER_FAIL_FLAG];
    wire sw_bit    = ctrl_q[`RTCTS_CTRL_CRS] ? phase_w[8] :
                     (ctrl_q[1:0] == 2'b00) ? phase_w[14] :
                     (ctrl_q[1:0] == 2'b01) ? phase_w[2] :
                     (ctrl_q[1:0] == 2'b10) ? phase_w[1] : div_q[0];
    wire alm0 = ctrl_q[`RTCTS_CTRL_ALARM_ZERO_ENABLE];
    wire alm1 = ctrl_q[`RTCTS_CTRL_ALARM_ONE_ENABLE];

    always @* begin
        if (ctrl_q[`RTCTS_CTRL_SQUARE_WAVE_ENABLE]) begin
            // square wave and 64 Hz both dropped on backup
            level_d = backup_q ? 1'b1 : sw_bit;
        end else if (alm0 || alm1) begin
            if (alarm_polarity_q)
                level_d = (alm0 & alarm_zero_flag_i) | (alm1 & alarm_one_flag_i);
            else
                level_d = !((!alm0 | alarm_zero_flag_i) & (!alm1 | alarm_one_flag_i)
                            & (alm0 | alm1));
        end else begin
            level_d = backup_q ? 1'b1 : ctrl_q[`RTCTS_CTRL_OUT];
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q           <= `RTCTS_CTRL_RESET;
            trim_q           <= `RTCTS_TRIM_RESET;
            vbat_en_q        <= 1'b0;
            pwr_fail_q       <= 1'b0;
            alarm_polarity_q <= 1'b0;
            backup_q         <= 1'b0;
            div_q            <= 15'h0000;
            for (i = 0; i < 4; i = i + 1) begin
                pd_q[i] <= 8'h00;
                pu_q[i] <= 8'h00;
            end
            reg_rdata_o  <= 8'h00;
            bus_enable_o <= 1'b1;
            on_backup_o  <= 1'b0;
            mfp_o        <= 1'b1;
            mfp_oe_n_o   <= 1'b1;
            time_phase_o <= {CNT_W{1'b0}};
        end else if (ce_i) begin
            if (osc_tick_i)
                div_q <= div_q + 15'h0001;
            backup_q     <= go_backup;
            on_backup_o  <= go_backup;
            bus_enable_o <= !go_backup;
            time_phase_o <= phase_w;
            mfp_o        <= level_d;
            // open drain: enable low only when pulling the pin low
            mfp_oe_n_o   <= level_d;
            if (bus_wr) begin
                case (reg_addr_i)
                    `RTCTS_ADDR_CONTROL: ctrl_q <= reg_wdata_i;
                    `RTCTS_ADDR_TRIM:    trim_q <= reg_wdata_i;
                    `RTCTS_ADDR_WKDAY:   vbat_en_q <= reg_wdata_i[`RTCTS_WK_BACKUP_INPUT_ENABLE];
                    `RTCTS_ADDR_ALM0WK,
                    `RTCTS_ADDR_ALM1WK:  alarm_polarity_q <= reg_wdata_i[`RTCTS_ALM_POL];
                    default: ;
                endcase
            end
            if (clr_flag) begin
                pwr_fail_q <= 1'b0;
                for (i = 0; i < 4; i = i + 1) begin
                    pd_q[i] <= 8'h00;
                    pu_q[i] <= 8'h00;
                end
            end
            // capture wins over clear in the same cycle
            if (go_backup && !backup_q && (!pwr_fail_q || clr_flag)) begin
                pwr_fail_q <= 1'b1;
                pd_q[0] <= cal_min_i & stamp_mask(2'd0);
                pd_q[1] <= cal_hour_i & stamp_mask(2'd1);
                pd_q[2] <= cal_date_i & stamp_mask(2'd2);
                pd_q[3] <= cal_mth_i;
            end
            if (!go_backup && backup_q && pwr_fail_q && pu_q[3] == 8'h00) begin
                pu_q[0] <= cal_min_i & stamp_mask(2'd0);
                pu_q[1] <= cal_hour_i & stamp_mask(2'd1);
                pu_q[2] <= cal_date_i & stamp_mask(2'd2);
                pu_q[3] <= cal_mth_i;
            end
            case (reg_addr_i)
                `RTCTS_ADDR_CONTROL: reg_rdata_o <= ctrl_q;
                `RTCTS_ADDR_TRIM:    reg_rdata_o <= trim_q;
                `RTCTS_ADDR_WKDAY:   reg_rdata_o <= {3'b000, pwr_fail_q, vbat_en_q, 3'b000};
                `RTCTS_ADDR_ALM0WK:  reg_rdata_o <= {alarm_polarity_q, 3'b000,
                                                     alarm_zero_flag_i, 3'b000};
                `RTCTS_ADDR_ALM1WK:  reg_rdata_o <= {alarm_polarity_q, 3'b000,
                                                     alarm_one_flag_i, 3'b000};
                5'h18, 5'h19, 5'h1A, 5'h1B: reg_rdata_o <= pd_q[reg_addr_i[1:0]];
                5'h1C, 5'h1D, 5'h1E, 5'h1F: reg_rdata_o <= pu_q[reg_addr_i[1:0]];
                default:             reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule // rtcts_core

// ===== tb/rtcts_core_props.sv
// assertions on the pin, trim and backup ports of rtcts_core
`timescale 1ns/10ps
module rtcts_core_props #(
    parameter CNT_W = 21
) (
    input wire             clock_i,
    input wire             rst_n_i,
    input wire             ce_i,
    input wire             osc_tick_i,
    input wire             vcc_below_trip_i,
    input wire             reg_wr_i,
    input wire [4:0]       reg_addr_i,
    input wire [7:0]       reg_wdata_i,
    input wire [7:0]       reg_rdata_o,
    input wire             bus_enable_o,
    input wire             on_backup_o,
    input wire             mfp_o,
    input wire [CNT_W-1:0] time_phase_o
);
    reg  [7:0] ctrl_q;
    reg  [7:0] trim_q;
    reg  [7:0] quiet_q;
    reg        vbat_q;
    // shadow copies; writes on backup are refused, so the shadow refuses them too
    wire       wr_ok = ce_i && reg_wr_i && !on_backup_o;
    wire       gpo_c = ctrl_q[6:4] == 3'b000 && !on_backup_o;
    wire       crs_c = ctrl_q[6] && ctrl_q[2] && !on_backup_o;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q  <= 8'h80;
            trim_q  <= 8'h00;
            quiet_q <= 8'hFF;
            vbat_q  <= 1'b0;
        end else begin
            if (wr_ok && reg_addr_i == 5'h07) ctrl_q <= reg_wdata_i;
            if (wr_ok && reg_addr_i == 5'h08) trim_q <= reg_wdata_i;
            if (wr_ok && reg_addr_i == 5'h03) vbat_q <= reg_wdata_i[3];
            // a latched step may run on for up to 254 ticks after trim is cleared
            if (trim_q[6:0] != 7'h00 || ctrl_q[2])
                quiet_q <= 8'h00;
            else if (ce_i && osc_tick_i && quiet_q != 8'hFF)
                quiet_q <= quiet_q + 8'h01;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_gpo_level: assert property ((gpo_c && $stable(ctrl_q))[*3] |-> mfp_o == ctrl_q[7])
        else $error("general output level wrong");
    a_bus_off: assert property (on_backup_o |-> !bus_enable_o)
        else $error("bus left on during backup");
    a_backup_idle: assert property (on_backup_o && $past(on_backup_o) && ctrl_q[5:4] == 2'b00 |-> mfp_o)
        else $error("pin driven during backup");
    a_backup_entry: assert property (vcc_below_trip_i && vbat_q && !on_backup_o |=> on_backup_o)
        else $error("no switch to backup");
    a_backup_exit: assert property (!vcc_below_trip_i && on_backup_o |=> !on_backup_o)
        else $error("no return to primary");
    a_vbat_gate: assert property (!vbat_q && !on_backup_o |=> !on_backup_o)
        else $error("backup without input enable");
    a_read_ctrl: assert property ((reg_addr_i == 5'h07 && !reg_wr_i && ce_i)[*2] |-> reg_rdata_o == ctrl_q)
        else $error("control readback wrong");
    a_phase_step: assert property (osc_tick_i && ce_i && quiet_q == 8'hFF ##1 ce_i ##1 1'b1
        |-> time_phase_o == $past(time_phase_o, 2) + 1'b1)
        else $error("timebase trimmed with zero magnitude");
    a_coarse_clk: assert property ((crs_c && $stable(time_phase_o[8]) && $stable(ctrl_q))[*3]
        |-> mfp_o == time_phase_o[8])
        else $error("coarse clock not on pin");
    c_backup: cover property ($rose(on_backup_o));
    c_coarse: cover property (crs_c && mfp_o);
    c_gpo_low: cover property (gpo_c && !mfp_o);
endmodule // rtcts_core_props

bind rtcts_core rtcts_core_props #(.CNT_W(CNT_W)) u_props (.*);

// ===== tb/rtcts_pin_pullup.sv
// far side of the open-drain pin: pull-up resistor seen by the host
`timescale 1ns/10ps
module rtcts_pin_pullup (
    input  wire mfp_oe_n_i,
    output wire pin_o
);
    // released pin floats up to the supply, never keeps the last value
    assign pin_o = mfp_oe_n_i ? 1'b1 : 1'b0;
endmodule // rtcts_pin_pullup

// ===== tb/rtcts_core_tb.sv
// self-checking bench for rtcts_core
`timescale 1ns/10ps
module rtcts_core_tb;
    reg         clock_i = 0;
    reg         rst_n_i = 0;
    reg         ce = 1;
    // trim from a 3 ppm slow clock: sign set, magnitude by the ppm formula
    localparam [7:0] CAL_TRIM = 8'h80 | ((3 * 32768 * 60) / (1000000 * 2));
    reg         osc_tick_i = 0;
    reg  [1:0]  tick_q = 0;
    reg         trip = 0;
    reg         wr = 0;
    reg  [4:0]  addr = 0;
    reg  [7:0]  wd = 0;
    reg  [7:0]  mn = 8'h45;
    reg  [7:0]  hr = 8'h12;
    reg  [7:0]  dt = 8'h28;
    reg  [7:0]  mo = 8'h09;
    wire [7:0]  rd;
    wire        bus_en, backup, multi_function_pin, oe_n, pin;
    wire [20:0] phase;
    integer     bad_count = 0, samples_checked = 0, i;
    reg  [8:0]  rows [0:5] = '{9'h101, 9'h000, 9'h021, 9'h040, 9'h061, 9'h010};
    reg  [7:0]  pd [0:3] = '{8'h45, 8'h12, 8'h28, 8'h09};
    reg  [7:0]  pu [0:3] = '{8'h46, 8'h13, 8'h29, 8'h10};
    rtcts_core u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .osc_tick_i(osc_tick_i),
        .vcc_below_trip_i(trip), .cal_min_i(mn), .cal_hour_i(hr), .cal_date_i(dt), .cal_mth_i(mo),
        .alarm_zero_flag_i(1'b1), .alarm_one_flag_i(1'b0), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_rdata_o(rd), .bus_enable_o(bus_en), .on_backup_o(backup),
        .mfp_o(multi_function_pin), .mfp_oe_n_o(oe_n), .time_phase_o(phase));
    rtcts_pin_pullup u_pin (.mfp_oe_n_i(oe_n), .pin_o(pin));
    initial forever #4 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        tick_q <= tick_q + 2'd1;
        osc_tick_i <= (tick_q == 2'd0);
    end
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wreg(input [4:0] a, input [7:0] d);
        begin
            @(posedge clock_i);
            wr <= 1'b1;
            addr <= a;
            wd <= d;
            @(posedge clock_i);
            wr <= 1'b0;
        end
    endtask
    task rchk(input [4:0] a, input [7:0] e);
        begin
            @(posedge clock_i);
            addr <= a;
            repeat (2) @(posedge clock_i);
            #1 chk("register", e, rd);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        #160000;
        bad_count = bad_count + 1;
        final_report;
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rchk(5'h07, 8'h80);
        rchk(5'h08, 8'h00);
        rchk(5'h0A, 8'h00);
        wreg(5'h0D, 8'h80);
        wreg(5'h14, 8'h80);
        for (i = 0; i < 6; i = i + 1) begin
            wreg(5'h07, rows[i][8:1]);
            rchk(5'h07, rows[i][8:1]);
            chk("pin", {7'h0, rows[i][0]}, {7'h0, pin});
        end
        $display("output mode table done");
        // enable low: the write must not land
        ce <= 1'b0;
        wreg(5'h07, 8'h80);
        ce <= 1'b1;
        rchk(5'h07, 8'h08);
        $display("clock enable test done");
        wreg(5'h08, 8'h00);
        wreg(5'h07, 8'h40);
        repeat (64) @(posedge clock_i);
        wreg(5'h08, CAL_TRIM);
        rchk(5'h08, 8'h82);
        wreg(5'h08, 8'h81);
        rchk(5'h08, 8'h81);
        wreg(5'h07, 8'h47);
        repeat (3000) @(posedge clock_i);
        // coarse mode only for observation, never left on
        wreg(5'h07, 8'h80);
        wreg(5'h08, 8'h00);
        $display("coarse trim done");
        wreg(5'h03, 8'h08);
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge clock_i);
            trip <= 1'b1;
            repeat (3) @(posedge clock_i);
            #1 chk("backup", 8'h01, {7'h0, backup});
            chk("bus", 8'h00, {7'h0, bus_en});
            chk("pin", 8'h01, {7'h0, pin});
            wreg(5'h07, 8'h00);
            mn <= pu[0] + {i[6:0], 1'b0};
            hr <= pu[1];
            dt <= pu[2];
            mo <= pu[3];
            @(posedge clock_i);
            trip <= 1'b0;
            repeat (3) @(posedge clock_i);
        end
        rchk(5'h07, 8'h80);
        rchk(5'h03, 8'h18);
        for (i = 0; i < 4; i = i + 1) begin
            rchk(5'h18 + i[4:0], pd[i]);
            rchk(5'h1C + i[4:0], pu[i]);
        end
        wreg(5'h03, 8'h08);
        rchk(5'h03, 8'h08);
        for (i = 0; i < 4; i = i + 1) begin
            rchk(5'h18 + i[4:0], 8'h00);
            rchk(5'h1C + i[4:0], 8'h00);
        end
        $display("power fail stamps done");
        final_report;
    end
endmodule // rtcts_core_tb
